// ---- src/ufi_pkg.sv ----
// constants of the usb function interrupt status and mask block
// Behaviour
// - any change of interface event status raises the third usb interrupt line while mask bit 5 is 0
// - interface event status is read-only, 8 bits; writes leave it unchanged
// - writing 0 to a clear register bit forces that status bit to 0; a set event in the same cycle still wins
// - endpoint status bits are invalid when endpoint is not in current setting
// - automatic set-interface handling sets status bit 5 and raises interrupt
// - current alternate setting is readable after automatic interface selection
// - device event mask is read/write in bits 7,6,2,1,0 at address ff37; bits 5..3 read 0
// - mask bit 1 suppresses first usb interrupt for that source; 0 passes
// - mask bit 7 gates bus reset
// - mask bit 6 gates resume/suspend
// - mask bits 2,1,0 gate set-feature, clear-feature, endpoint halt
// - mask register reads 00 after reset
// - bulk-out data flag set when both fifos hold data, cleared on toggle
package ufi_pkg;
    // -----------------------------------------------------------------
    // register addresses
    // -----------------------------------------------------------------
    localparam logic [15:0] ADDR_DEV_STATUS   = 16'hff27;
    localparam logic [15:0] ADDR_BULK_STATUS  = 16'hff2a;
    localparam logic [15:0] ADDR_IF_STATUS    = 16'hff2b;
    localparam logic [15:0] ADDR_DEV_MASK     = 16'hff37;
    localparam logic [15:0] ADDR_BULK_MASK    = 16'hff3a;
    localparam logic [15:0] ADDR_IF_MASK      = 16'hff3b;
    localparam logic [15:0] ADDR_DEV_CLEAR    = 16'hff4a;
    localparam logic [15:0] ADDR_BULK_CLEAR   = 16'hff4d;
    localparam logic [15:0] ADDR_IF_CLEAR     = 16'hff4e;
    localparam logic [15:0] ADDR_ALT_SETTING  = 16'hff51;
    localparam logic [15:0] ADDR_EP_MAP       = 16'hff52;
    // -----------------------------------------------------------------
    // field positions and implemented-bit patterns
    // -----------------------------------------------------------------
    localparam int          BIT_BUS_RESET     = 7;
    localparam int          BIT_RESUME_SUSP   = 6;
    localparam int          BIT_SET_FEATURE   = 2;
    localparam int          BIT_CLR_FEATURE   = 1;
    localparam int          BIT_ENDPOINT_HALT_EVENT       = 0;
    localparam int          BIT_SET_IF_DONE   = 5;
    localparam int          BIT_BULK_FULL     = 3;
    localparam int          BIT_BULK_NULL     = 2;
    localparam int          BIT_BULK_NAK      = 1;
    localparam int          BIT_BULK_DONE     = 0;
    localparam logic [7:0]  DEV_IMPL          = 8'hc7;
    localparam logic [7:0]  BULK_IMPL         = 8'h0f;
    localparam logic [7:0]  IF_IMPL           = 8'h20;
    localparam logic [7:0]  RESET_BYTE        = 8'h00;
    localparam logic [7:0]  CLEAR_READ_BYTE   = 8'hff;
endpackage

// ---- src/ufi_group.sv ----
// one sticky status group with write-zero clear and mask
module ufi_group
    import ufi_pkg::*;
#(
    parameter logic [7:0] IMPL = 8'hff
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // events and control
    input  wire logic [7:0] set_in,
    input  wire logic [7:0] hw_clr_in,
    input  wire logic       clr_wr_in,
    input  wire logic       mask_wr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic [7:0] valid_in,
    // state
    output logic      [7:0] status_out,
    output logic      [7:0] mask_out,
    output logic            pend_out
);
    logic [7:0] status_d;
    logic [7:0] clr_hit;

    // a zero written to the clear register clears; set still wins
    assign clr_hit  = clr_wr_in ? ~wdata_in : 8'h00;
    assign status_d = ((status_out & ~clr_hit & ~hw_clr_in) | set_in) & IMPL;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_out <= RESET_BYTE;
        end else begin
            status_out <= status_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_out <= RESET_BYTE;
        end else if (mask_wr_in) begin
            mask_out <= wdata_in & IMPL;
        end
    end

    // invalid endpoint bits never request
    assign pend_out = |(status_out & ~mask_out & valid_in);
endmodule

// ---- src/ufi_irq_top.sv ----
// usb function interrupt status, mask and clear registers
module ufi_irq_top
    import ufi_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESET_N_IN,
    // register port
    input  wire logic [15:0] ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [7:0]  RDATA_OUT,
    // device event sources, one-cycle pulses
    input  wire logic        BUS_RESET_EV_IN,
    input  wire logic        RESUME_SUSPEND_EV_IN,
    input  wire logic        SET_FEATURE_EV_IN,
    input  wire logic        CLEAR_FEATURE_EV_IN,
    input  wire logic        ENDPOINT_HALT_EV_IN,
    // bulk-out endpoint sources
    input  wire logic        BULK_NULL_EV_IN,
    input  wire logic        BULK_NAK_EV_IN,
    input  wire logic        BULK_DONE_EV_IN,
    input  wire logic        BULK_BOTH_FULL_IN,
    input  wire logic        BULK_TOGGLE_IN,
    // interface selection
    input  wire logic        SET_IF_DONE_IN,
    input  wire logic [7:0]  ALT_SETTING_IN,
    input  wire logic        BULK_EP_IN_SETTING_IN,
    // interrupt lines, active high
    output logic             USB_IRQ_FIRST_OUT,
    output logic             USB_IRQ_SECOND_OUT,
    output logic             USB_IRQ_THIRD_OUT
);
    import ufi_pkg::*;

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        hit = (a == r);
    endfunction

    logic [7:0] dev_set;
    logic [7:0] bulk_set;
    logic [7:0] bulk_hclr;
    logic [7:0] if_set;
    logic [7:0] dev_status;
    logic [7:0] dev_mask;
    logic [7:0] bulk_status;
    logic [7:0] bulk_mask;
    logic [7:0] if_status;
    logic [7:0] if_mask;
    logic       dev_pend;
    logic       bulk_pend;
    logic       if_pend;
    logic [7:0] ep_map_q;
    logic [7:0] alt_q;
    logic [7:0] bulk_valid;
    logic [7:0] if_prev_q;
    logic       if_chg_q;
    logic [7:0] rdata_d;

    // -----------------------------------------------------------------
    // event mapping
    // -----------------------------------------------------------------
    always_comb begin
        dev_set = 8'h00;
        dev_set[BIT_BUS_RESET]   = BUS_RESET_EV_IN;
        dev_set[BIT_RESUME_SUSP] = RESUME_SUSPEND_EV_IN;
        dev_set[BIT_SET_FEATURE] = SET_FEATURE_EV_IN;
        dev_set[BIT_CLR_FEATURE] = CLEAR_FEATURE_EV_IN;
        dev_set[BIT_ENDPOINT_HALT_EVENT]     = ENDPOINT_HALT_EV_IN;
        bulk_set = 8'h00;
        bulk_set[BIT_BULK_NULL]  = BULK_NULL_EV_IN;
        bulk_set[BIT_BULK_NAK]   = BULK_NAK_EV_IN;
        bulk_set[BIT_BULK_DONE]  = BULK_DONE_EV_IN;
        bulk_set[BIT_BULK_FULL]  = BULK_BOTH_FULL_IN & ~BULK_TOGGLE_IN;
        bulk_hclr = 8'h00;
        bulk_hclr[BIT_BULK_FULL] = BULK_TOGGLE_IN;
        if_set = 8'h00;
        if_set[BIT_SET_IF_DONE]  = SET_IF_DONE_IN;
    end

    // endpoint valid only when mapped and in the current setting
    assign bulk_valid = (ep_map_q[0] & BULK_EP_IN_SETTING_IN) ? 8'hff : 8'h00;

    // -----------------------------------------------------------------
    // status groups
    // -----------------------------------------------------------------
    ufi_group #(.IMPL(DEV_IMPL)) u_dev (
        .clk_in     (CORE_CLK_IN),
        .rst_n_in   (RESET_N_IN),
        .set_in     (dev_set),
        .hw_clr_in  (8'h00),
        .clr_wr_in  (WR_IN && hit(ADDR_IN, ADDR_DEV_CLEAR)),
        .mask_wr_in (WR_IN && hit(ADDR_IN, ADDR_DEV_MASK)),
        .wdata_in   (WDATA_IN),
        .valid_in   (8'hff),
        .status_out (dev_status),
        .mask_out   (dev_mask),
        .pend_out   (dev_pend)
    );

    ufi_group #(.IMPL(BULK_IMPL)) u_bulk (
        .clk_in     (CORE_CLK_IN),
        .rst_n_in   (RESET_N_IN),
        .set_in     (bulk_set),
        .hw_clr_in  (bulk_hclr),
        .clr_wr_in  (WR_IN && hit(ADDR_IN, ADDR_BULK_CLEAR)),
        .mask_wr_in (WR_IN && hit(ADDR_IN, ADDR_BULK_MASK)),
        .wdata_in   (WDATA_IN),
        .valid_in   (bulk_valid),
        .status_out (bulk_status),
        .mask_out   (bulk_mask),
        .pend_out   (bulk_pend)
    );

    // status itself has no write path: only set and clear change it
    ufi_group #(.IMPL(IF_IMPL)) u_if (
        .clk_in     (CORE_CLK_IN),
        .rst_n_in   (RESET_N_IN),
        .set_in     (if_set),
        .hw_clr_in  (8'h00),
        .clr_wr_in  (WR_IN && hit(ADDR_IN, ADDR_IF_CLEAR)),
        .mask_wr_in (WR_IN && hit(ADDR_IN, ADDR_IF_MASK)),
        .wdata_in   (WDATA_IN),
        .valid_in   (8'hff),
        .status_out (if_status),
        .mask_out   (if_mask),
        .pend_out   (if_pend)
    );

    // -----------------------------------------------------------------
    // configuration and alternate setting
    // -----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ep_map_q <= RESET_BYTE;
        end else if (WR_IN && hit(ADDR_IN, ADDR_EP_MAP)) begin
            ep_map_q <= WDATA_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            alt_q <= RESET_BYTE;
        end else if (SET_IF_DONE_IN) begin
            alt_q <= ALT_SETTING_IN;
        end
    end

    // change of the interface status also requests, even when cleared
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            if_prev_q <= RESET_BYTE;
            if_chg_q  <= 1'b0;
        end else begin
            if_prev_q <= if_status;
            if_chg_q  <= (if_prev_q != if_status) && !if_mask[BIT_SET_IF_DONE];
        end
    end

    // -----------------------------------------------------------------
    // interrupt lines, registered
    // -----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            USB_IRQ_FIRST_OUT  <= 1'b0;
            USB_IRQ_SECOND_OUT <= 1'b0;
            USB_IRQ_THIRD_OUT  <= 1'b0;
        end else begin
            USB_IRQ_FIRST_OUT  <= dev_pend;
            USB_IRQ_SECOND_OUT <= bulk_pend;
            USB_IRQ_THIRD_OUT  <= if_pend | if_chg_q;
        end
    end

    // -----------------------------------------------------------------
    // read mux
    // -----------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (hit(ADDR_IN, ADDR_DEV_STATUS)) begin
            rdata_d = dev_status;
        end else if (hit(ADDR_IN, ADDR_BULK_STATUS)) begin
            rdata_d = bulk_status & bulk_valid;
        end else if (hit(ADDR_IN, ADDR_IF_STATUS)) begin
            rdata_d = if_status;
        end else if (hit(ADDR_IN, ADDR_DEV_MASK)) begin
            rdata_d = dev_mask;
        end else if (hit(ADDR_IN, ADDR_BULK_MASK)) begin
            rdata_d = bulk_mask;
        end else if (hit(ADDR_IN, ADDR_IF_MASK)) begin
            rdata_d = if_mask;
        end else if (hit(ADDR_IN, ADDR_DEV_CLEAR) || hit(ADDR_IN, ADDR_BULK_CLEAR)
                     || hit(ADDR_IN, ADDR_IF_CLEAR)) begin
            rdata_d = CLEAR_READ_BYTE;
        end else if (hit(ADDR_IN, ADDR_ALT_SETTING)) begin
            rdata_d = alt_q;
        end else if (hit(ADDR_IN, ADDR_EP_MAP)) begin
            rdata_d = ep_map_q;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (RD_IN) begin
            RDATA_OUT <= rdata_d;
        end else begin
            RDATA_OUT <= 8'h00;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    property p_setif_irq;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        SET_IF_DONE_IN && !if_mask[BIT_SET_IF_DONE] |=> ##1 USB_IRQ_THIRD_OUT;
    endproperty
    a_setif_irq: assert property (p_setif_irq) else $error("set-interface irq missing");

    property p_setif_bit;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        SET_IF_DONE_IN |=> if_status[BIT_SET_IF_DONE];
    endproperty
    a_setif_bit: assert property (p_setif_bit) else $error("status bit 5 not set");

    property p_if_clear;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        WR_IN && hit(ADDR_IN, ADDR_IF_CLEAR) && !WDATA_IN[BIT_SET_IF_DONE]
            && !SET_IF_DONE_IN |=> !if_status[BIT_SET_IF_DONE];
    endproperty
    a_if_clear: assert property (p_if_clear) else $error("clear by zero failed");

    property p_if_ro;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        WR_IN && hit(ADDR_IN, ADDR_IF_STATUS) && !SET_IF_DONE_IN |=> $stable(if_status);
    endproperty
    a_if_ro: assert property (p_if_ro) else $error("status changed by write");

    property p_mask_rd;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        WR_IN && hit(ADDR_IN, ADDR_DEV_MASK) ##1 RD_IN && hit(ADDR_IN, ADDR_DEV_MASK)
            |=> RDATA_OUT == ($past(WDATA_IN, 2) & DEV_IMPL);
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");

    property p_first_masked;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        ((dev_status & ~dev_mask) == 8'h00) |=> !USB_IRQ_FIRST_OUT;
    endproperty
    a_first_masked: assert property (p_first_masked) else $error("masked source fired");

    property p_bus_reset;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        BUS_RESET_EV_IN && !dev_mask[BIT_BUS_RESET] |=> ##1 USB_IRQ_FIRST_OUT;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("bus reset irq missing");

    property p_bulk_invalid;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        !(ep_map_q[0] && BULK_EP_IN_SETTING_IN) |=> !USB_IRQ_SECOND_OUT;
    endproperty
    a_bulk_invalid: assert property (p_bulk_invalid) else $error("invalid ep raised irq");

    property p_toggle_clr;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        BULK_TOGGLE_IN |=> !bulk_status[BIT_BULK_FULL];
    endproperty
    a_toggle_clr: assert property (p_toggle_clr) else $error("full flag kept on toggle");

    property p_first_line;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        dev_pend |=> USB_IRQ_FIRST_OUT;
    endproperty
    a_first_line: assert property (p_first_line) else $error("first irq not raised");

    property p_second_line;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        bulk_pend |=> USB_IRQ_SECOND_OUT;
    endproperty
    a_second_line: assert property (p_second_line) else $error("second irq not raised");

    property p_third_quiet;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        !if_pend && !if_chg_q |=> !USB_IRQ_THIRD_OUT;
    endproperty
    a_third_quiet: assert property (p_third_quiet) else $error("third irq with no cause");

    // the change path lags the pending path by one cycle
    property p_if_change;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        $changed(if_status) && !if_mask[BIT_SET_IF_DONE] |=> ##1 USB_IRQ_THIRD_OUT;
    endproperty
    a_if_change: assert property (p_if_change) else $error("status change gave no irq");

    property p_if_unused;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        (if_status & ~IF_IMPL) == 8'h00;
    endproperty
    a_if_unused: assert property (p_if_unused) else $error("unused status bit set");

    property p_dev_unused;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        (dev_mask & ~DEV_IMPL) == 8'h00;
    endproperty
    a_dev_unused: assert property (p_dev_unused) else $error("unused mask bit set");

    property p_alt_latch;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        SET_IF_DONE_IN |=> alt_q == $past(ALT_SETTING_IN);
    endproperty
    a_alt_latch: assert property (p_alt_latch) else $error("alternate setting not kept");

    property p_status_rd;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        RD_IN && hit(ADDR_IN, ADDR_IF_STATUS) |=> RDATA_OUT == $past(if_status);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status read wrong");

    property p_mask_hold;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        !(WR_IN && hit(ADDR_IN, ADDR_DEV_MASK)) |=> $stable(dev_mask);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask changed with no write");

    property p_full_set;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        BULK_BOTH_FULL_IN && !BULK_TOGGLE_IN |=> bulk_status[BIT_BULK_FULL];
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set");

    property p_null_set;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        BULK_NULL_EV_IN |=> bulk_status[BIT_BULK_NULL];
    endproperty
    a_null_set: assert property (p_null_set) else $error("null flag not set");

    property p_dev_clear;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        WR_IN && hit(ADDR_IN, ADDR_DEV_CLEAR) && !WDATA_IN[BIT_BUS_RESET]
            && !BUS_RESET_EV_IN |=> !dev_status[BIT_BUS_RESET];
    endproperty
    a_dev_clear: assert property (p_dev_clear) else $error("bus reset flag not cleared");
endmodule

// ---- test/usb_function_irq_status_mask_bench.sv ----
// self-checking bench of the usb function interrupt status and mask block
module usb_function_irq_status_mask_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ufi_pkg::*;
    // -----------------------------------------------------------------
    // stimulus and observation
    // -----------------------------------------------------------------
    logic        clk;
    logic        rst_n;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [4:0]  dev_ev;
    logic [2:0]  bulk_ev;
    logic        full;
    logic        toggle;
    logic        set_if;
    logic [7:0]  alt;
    logic        ep_ok;
    logic        irq0;
    logic        irq1;
    logic        irq2;
    logic [7:0]  m;
    logic [7:0]  v;
    int          p;
    int          miscompares;
    int          n_checks;

    ufi_irq_top uut (
        .CORE_CLK_IN           (clk),
        .RESET_N_IN            (rst_n),
        .ADDR_IN               (addr),
        .WDATA_IN              (wdata),
        .WR_IN                 (wr),
        .RD_IN                 (rd),
        .RDATA_OUT             (rdata),
        .BUS_RESET_EV_IN       (dev_ev[4]),
        .RESUME_SUSPEND_EV_IN  (dev_ev[3]),
        .SET_FEATURE_EV_IN     (dev_ev[2]),
        .CLEAR_FEATURE_EV_IN   (dev_ev[1]),
        .ENDPOINT_HALT_EV_IN   (dev_ev[0]),
        .BULK_NULL_EV_IN       (bulk_ev[2]),
        .BULK_NAK_EV_IN        (bulk_ev[1]),
        .BULK_DONE_EV_IN       (bulk_ev[0]),
        .BULK_BOTH_FULL_IN     (full),
        .BULK_TOGGLE_IN        (toggle),
        .SET_IF_DONE_IN        (set_if),
        .ALT_SETTING_IN        (alt),
        .BULK_EP_IN_SETTING_IN (ep_ok),
        .USB_IRQ_FIRST_OUT     (irq0),
        .USB_IRQ_SECOND_OUT    (irq1),
        .USB_IRQ_THIRD_OUT     (irq2)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // source index 4..3 sits at status bits 7..6, the rest keep their index
    function automatic int dev_pos(input int i);
        return (i >= 3) ? i + 3 : i;
    endfunction
    task automatic test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data live only in the cycle after the strobe, so sample there
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_byte(what, exp, rdata);
    endtask
    // write then read back with no gap between the strobes
    task automatic wr_rd_chk(input string what, input logic [15:0] a, input logic [7:0] d,
                             input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_byte(what, exp, rdata);
    endtask
    task automatic dev_pulse(input int i);
        @(posedge clk);
        dev_ev <= 5'h01 << i;
        @(posedge clk);
        dev_ev <= 5'h00;
    endtask
    task automatic bulk_pulse(input int i);
        @(posedge clk);
        bulk_ev <= 3'h1 << i;
        @(posedge clk);
        bulk_ev <= 3'h0;
    endtask
    task automatic if_pulse(input logic [7:0] a);
        @(posedge clk);
        alt <= a;
        set_if <= 1'b1;
        @(posedge clk);
        set_if <= 1'b0;
    endtask
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        {rst_n, wr, rd, full, toggle, set_if} = 6'h00;
        {addr, wdata, alt, dev_ev, bulk_ev} = '0;
        ep_ok = 1'b1;
        miscompares = 0;
        n_checks = 0;
        void'($urandom(71));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("dev mask", ADDR_DEV_MASK, RESET_BYTE);
        rd_chk("if status", ADDR_IF_STATUS, RESET_BYTE);
        rd_chk("if clear", ADDR_IF_CLEAR, CLEAR_READ_BYTE);
        rd_chk("unmapped", 16'hff00, 8'h00);
        reg_wr(ADDR_DEV_MASK, 8'hff);
        rd_chk("dev mask", ADDR_DEV_MASK, 8'hc7);
        // first pass with the source masked, second with it open
        for (int k = 0; k < 10; k++) begin
            p = dev_pos(k % 5);
            m = 8'($urandom);
            m[p] = (k < 5);
            wr_rd_chk("dev mask", ADDR_DEV_MASK, m, m & 8'hc7);
            dev_pulse(k % 5);
            settle(2);
            chk_bit("first irq", ~m[p], irq0);
            rd_chk("dev status", ADDR_DEV_STATUS, 8'h01 << p);
            reg_wr(ADDR_DEV_CLEAR, ~(8'h01 << p));
            settle(2);
            chk_bit("first irq", 1'b0, irq0);
            rd_chk("dev status", ADDR_DEV_STATUS, 8'h00);
        end
        reg_wr(ADDR_EP_MAP, 8'h01);
        for (int k = 0; k < 3; k++) begin
            bulk_pulse(k);
            settle(2);
            chk_bit("second irq", 1'b1, irq1);
            rd_chk("bulk status", ADDR_BULK_STATUS, 8'h01 << k);
            reg_wr(ADDR_BULK_CLEAR, ~(8'h01 << k));
            settle(2);
            chk_bit("second irq", 1'b0, irq1);
        end
        // masked bulk flag stays quiet until the mask opens
        reg_wr(ADDR_BULK_MASK, 8'hff);
        rd_chk("bulk mask", ADDR_BULK_MASK, 8'h0f);
        bulk_pulse(0);
        settle(2);
        chk_bit("second irq", 1'b0, irq1);
        reg_wr(ADDR_BULK_MASK, 8'h00);
        settle(2);
        chk_bit("second irq", 1'b1, irq1);
        reg_wr(ADDR_BULK_CLEAR, 8'hfe);
        @(posedge clk);
        full <= 1'b1;
        settle(2);
        rd_chk("bulk status", ADDR_BULK_STATUS, 8'h08);
        chk_bit("second irq", 1'b1, irq1);
        @(posedge clk);
        full <= 1'b0;
        toggle <= 1'b1;
        @(posedge clk);
        toggle <= 1'b0;
        settle(2);
        rd_chk("bulk status", ADDR_BULK_STATUS, 8'h00);
        chk_bit("second irq", 1'b0, irq1);
        // endpoint dropped from the setting hides its flags
        bulk_pulse(2);
        @(posedge clk);
        ep_ok <= 1'b0;
        rd_chk("bulk status", ADDR_BULK_STATUS, 8'h00);
        @(posedge clk);
        ep_ok <= 1'b1;
        rd_chk("bulk status", ADDR_BULK_STATUS, 8'h04);
        reg_wr(ADDR_BULK_CLEAR, 8'hfb);
        v = 8'($urandom);
        if_pulse(v);
        settle(2);
        chk_bit("third irq", 1'b1, irq2);
        rd_chk("if status", ADDR_IF_STATUS, 8'h20);
        rd_chk("alt setting", ADDR_ALT_SETTING, v);
        reg_wr(ADDR_IF_STATUS, 8'h00);
        rd_chk("if status", ADDR_IF_STATUS, 8'h20);
        reg_wr(ADDR_IF_CLEAR, 8'hdf);
        // the clear is itself a change, so let its short pulse pass first
        settle(5);
        chk_bit("third irq", 1'b0, irq2);
        rd_chk("if status", ADDR_IF_STATUS, 8'h00);
        reg_wr(ADDR_IF_MASK, 8'hff);
        rd_chk("if mask", ADDR_IF_MASK, 8'h20);
        if_pulse(v);
        repeat (5) begin
            settle(1);
            chk_bit("third irq", 1'b0, irq2);
        end
        rd_chk("if status", ADDR_IF_STATUS, 8'h20);
        test_done;
    end
    // -----------------------------------------------------------------
    // watchdog, far beyond the few hundred cycles the tests need
    // -----------------------------------------------------------------
    initial begin
        #400000;
        miscompares++;
        test_done;
    end
endmodule
